//--- shared/flash_host_params.svh
// timing, width and default opcode constants for the flash command host
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

`define FH_CLK_MHZ 10
`define FH_ADDR_W 20
`define FH_DATA_W 16
`define FH_CNT_W 8

// pin timing in ns, converted to whole clock cycles (least times round up)
`define FH_WE_LOW_NS 50
`define FH_WE_HIGH_NS 30
`define FH_OE_ACC_NS 100
`define FH_RP_LOW_NS 100
`define FH_WE_LOW_CYC ((`FH_WE_LOW_NS * `FH_CLK_MHZ + 999) / 1000)
`define FH_WE_HIGH_CYC ((`FH_WE_HIGH_NS * `FH_CLK_MHZ + 999) / 1000)
`define FH_OE_ACC_CYC ((`FH_OE_ACC_NS * `FH_CLK_MHZ + 999) / 1000)
`define FH_RP_LOW_CYC ((`FH_RP_LOW_NS * `FH_CLK_MHZ + 999) / 1000)

// status byte bit positions
`define FH_SR_READY 7
`define FH_SR_ERS_SUSP 6
`define FH_SR_CLR_ERR 5
`define FH_SR_SET_ERR 4
`define FH_SR_SUPPLY 3
`define FH_SR_PRG_SUSP 2
`define FH_SR_PROTECT 1

// default opcodes, overridable per instance
`define FH_OP_ERS_SUSP 8'hb0
`define FH_OP_ERS_RES 8'hd0
`define FH_OP_PRG_SUSP 8'hb0
`define FH_OP_PRG_RES 8'hd0
`define FH_OP_LOCK_SETUP 8'h60
`define FH_OP_LOCK_SET 8'h01
`define FH_OP_LOCK_CLR 8'hd0
`define FH_OP_CLR_STATUS 8'h50

`endif

//--- shared/flash_host_pkg.sv
// types for the flash suspend and lock-bit command host
`include "flash_host_params.svh"

package flash_host_pkg;

    typedef enum logic [2:0] {
        CMD_ERS_SUSP,
        CMD_ERS_RES,
        CMD_PRG_SUSP,
        CMD_PRG_RES,
        CMD_LOCK_SET,
        CMD_LOCK_CLR
    } cmd_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_WR1,
        S_WR2,
        S_POLL,
        S_CLR,
        S_RST
    } state_t;

    // pin-side bundle
    typedef struct packed {
        logic [`FH_ADDR_W-1:0] addr;
        logic [`FH_DATA_W-1:0] dq_out;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rp_n;
        logic wp_n;
    } pins_t;

    // whole controller state
    typedef struct packed {
        state_t state;
        logic phase;
        logic [`FH_CNT_W-1:0] cnt;
        cmd_t cmd;
        pins_t pins;
        logic busy;
        logic done;
        logic err;
        logic relock;
        logic [7:0] status;
    } ctl_t;

endpackage

//--- hw/flash_host.sv
// host controller issuing suspend, resume and lock-bit commands to a parallel flash
//
// Notes on behaviour
// - lock set is setup then confirm write
// - after lock set check set-error, clear status
// - lock clear is two writes, clears all
// - after lock clear check clear-error, clear status
// - aborted lock clear needs repeating
`timescale 1ns/1ps
`include "flash_host_params.svh"

module flash_host #(
    parameter logic [7:0] OP_ERS_SUSP = `FH_OP_ERS_SUSP,
    parameter logic [7:0] OP_ERS_RES = `FH_OP_ERS_RES,
    parameter logic [7:0] OP_PRG_SUSP = `FH_OP_PRG_SUSP,
    parameter logic [7:0] OP_PRG_RES = `FH_OP_PRG_RES,
    parameter logic [7:0] OP_LOCK_SETUP = `FH_OP_LOCK_SETUP,
    parameter logic [7:0] OP_LOCK_SET = `FH_OP_LOCK_SET,
    parameter logic [7:0] OP_LOCK_CLR = `FH_OP_LOCK_CLR,
    parameter logic [7:0] OP_CLR_STATUS = `FH_OP_CLR_STATUS
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // user request side
    input wire logic i_req_valid,
    input wire flash_host_pkg::cmd_t i_req_cmd,
    input wire logic [`FH_ADDR_W-1:0] i_req_addr,
    input wire logic i_abort,
    input wire logic i_unprotect,
    output logic o_busy,
    output logic o_done,
    output logic o_err,
    output logic o_relock_needed,
    output logic [7:0] o_status,
    // flash pins
    output logic [`FH_ADDR_W-1:0] o_flash_addr,
    output logic [`FH_DATA_W-1:0] o_dq_out,
    output logic o_dq_oe,
    input wire logic [`FH_DATA_W-1:0] i_dq_in,
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic o_rp_n,
    output logic o_wp_n,
    input wire logic i_status_pin
);

    localparam logic [`FH_CNT_W-1:0] WE_LOW_LAST = `FH_CNT_W'(`FH_WE_LOW_CYC - 1);
    localparam logic [`FH_CNT_W-1:0] WE_HIGH_LAST = `FH_CNT_W'(`FH_WE_HIGH_CYC - 1);
    localparam logic [`FH_CNT_W-1:0] OE_LAST = `FH_CNT_W'(`FH_OE_ACC_CYC - 1);
    localparam logic [`FH_CNT_W-1:0] RP_LAST = `FH_CNT_W'(`FH_RP_LOW_CYC - 1);

    localparam flash_host_pkg::pins_t PINS_IDLE = '{
        addr: '0, dq_out: '0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
        we_n: 1'b1, rp_n: 1'b1, wp_n: 1'b0};

    localparam flash_host_pkg::ctl_t CTL_RESET = '{
        state: flash_host_pkg::S_IDLE, phase: 1'b0, cnt: '0,
        cmd: flash_host_pkg::CMD_ERS_SUSP, pins: PINS_IDLE,
        busy: 1'b0, done: 1'b0, err: 1'b0, relock: 1'b0, status: 8'h00};

    flash_host_pkg::ctl_t st_r;
    flash_host_pkg::ctl_t st_nxt;

    // first write of each command
    function automatic logic [7:0] first_op(input flash_host_pkg::cmd_t c);
        case (c)
            flash_host_pkg::CMD_ERS_SUSP: first_op = OP_ERS_SUSP;
            flash_host_pkg::CMD_ERS_RES: first_op = OP_ERS_RES;
            flash_host_pkg::CMD_PRG_SUSP: first_op = OP_PRG_SUSP;
            flash_host_pkg::CMD_PRG_RES: first_op = OP_PRG_RES;
            default: first_op = OP_LOCK_SETUP;
        endcase
    endfunction

    // lock commands carry a confirm write
    function automatic logic two_writes(input flash_host_pkg::cmd_t c);
        two_writes = (c == flash_host_pkg::CMD_LOCK_SET) || (c == flash_host_pkg::CMD_LOCK_CLR);
    endfunction

    // start a write cycle on the pins
    function automatic flash_host_pkg::ctl_t begin_write(input flash_host_pkg::ctl_t s,
            input flash_host_pkg::state_t nst, input logic [7:0] op);
        begin_write = s;
        begin_write.state = nst;
        begin_write.phase = 1'b0;
        begin_write.cnt = '0;
        begin_write.pins.dq_out = {8'h00, op};
        begin_write.pins.dq_oe = 1'b1;
        begin_write.pins.ce_n = 1'b0;
        begin_write.pins.oe_n = 1'b1;
        begin_write.pins.we_n = 1'b0;
    endfunction

    // start a status read
    function automatic flash_host_pkg::ctl_t begin_poll(input flash_host_pkg::ctl_t s);
        begin_poll = s;
        begin_poll.state = flash_host_pkg::S_POLL;
        begin_poll.phase = 1'b0;
        begin_poll.cnt = '0;
        begin_poll.pins.dq_oe = 1'b0;
        begin_poll.pins.ce_n = 1'b0;
        begin_poll.pins.oe_n = 1'b0;
        begin_poll.pins.we_n = 1'b1;
    endfunction

    // back to idle with a one-cycle done
    function automatic flash_host_pkg::ctl_t finish(input flash_host_pkg::ctl_t s);
        finish = s;
        finish.state = flash_host_pkg::S_IDLE;
        finish.busy = 1'b0;
        finish.done = 1'b1;
        finish.pins.dq_oe = 1'b0;
        finish.pins.ce_n = 1'b1;
        finish.pins.oe_n = 1'b1;
        finish.pins.we_n = 1'b1;
        finish.pins.rp_n = 1'b1;
    endfunction

    logic lock_fail;

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.pins.wp_n = i_unprotect;
        lock_fail = 1'b0;
        if (i_abort && st_r.state != flash_host_pkg::S_RST) begin
            st_nxt.state = flash_host_pkg::S_RST;
            st_nxt.cnt = '0;
            st_nxt.busy = 1'b1;
            st_nxt.err = 1'b1;
            st_nxt.pins = PINS_IDLE;
            st_nxt.pins.wp_n = i_unprotect;
            st_nxt.pins.rp_n = 1'b0;
            if (st_r.busy && st_r.cmd == flash_host_pkg::CMD_LOCK_CLR) begin
                st_nxt.relock = 1'b1;
            end
        end else begin
            case (st_r.state)
                flash_host_pkg::S_IDLE: begin
                    if (i_req_valid) begin
                        st_nxt = begin_write(st_r, flash_host_pkg::S_WR1, first_op(i_req_cmd));
                        st_nxt.pins.wp_n = i_unprotect;
                        st_nxt.cmd = i_req_cmd;
                        st_nxt.pins.addr = i_req_addr;
                        st_nxt.busy = 1'b1;
                        st_nxt.err = 1'b0;
                    end
                end
                flash_host_pkg::S_WR1, flash_host_pkg::S_WR2, flash_host_pkg::S_CLR: begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                    if (!st_r.phase) begin
                        if (st_r.cnt == WE_LOW_LAST) begin
                            st_nxt.pins.we_n = 1'b1;
                            st_nxt.phase = 1'b1;
                            st_nxt.cnt = '0;
                        end
                    end else if (st_r.cnt == WE_HIGH_LAST) begin
                        if (st_r.state == flash_host_pkg::S_WR1 && two_writes(st_r.cmd)) begin
                            st_nxt = begin_write(st_r, flash_host_pkg::S_WR2,
                                (st_r.cmd == flash_host_pkg::CMD_LOCK_SET) ?
                                OP_LOCK_SET : OP_LOCK_CLR);
                        end else if (st_r.state == flash_host_pkg::S_CLR ||
                                st_r.cmd == flash_host_pkg::CMD_ERS_RES ||
                                st_r.cmd == flash_host_pkg::CMD_PRG_RES) begin
                            st_nxt = finish(st_r);
                        end else begin
                            st_nxt = begin_poll(st_r);
                        end
                    end
                end
                flash_host_pkg::S_POLL: begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                    if (!st_r.phase) begin
                        if (st_r.cnt == OE_LAST) begin
                            st_nxt.status = i_dq_in[7:0];
                            st_nxt.pins.oe_n = 1'b1;
                            st_nxt.phase = 1'b1;
                        end
                    end else if (!st_r.status[`FH_SR_READY] || !i_status_pin) begin
                        st_nxt = begin_poll(st_r);
                    end else begin
                        if (st_r.cmd == flash_host_pkg::CMD_LOCK_SET) begin
                            lock_fail = st_r.status[`FH_SR_SET_ERR];
                        end else if (st_r.cmd == flash_host_pkg::CMD_LOCK_CLR) begin
                            lock_fail = st_r.status[`FH_SR_CLR_ERR];
                        end
                        if (lock_fail) begin
                            st_nxt = begin_write(st_r, flash_host_pkg::S_CLR, OP_CLR_STATUS);
                            st_nxt.err = 1'b1;
                        end else begin
                            st_nxt = finish(st_r);
                            if (st_r.cmd == flash_host_pkg::CMD_LOCK_CLR) begin
                                st_nxt.relock = 1'b0;
                            end
                        end
                    end
                end
                flash_host_pkg::S_RST: begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                    if (st_r.cnt == RP_LAST) begin
                        st_nxt = finish(st_r);
                    end
                end
                default: st_nxt = CTL_RESET;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_r <= CTL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_busy = st_r.busy;
    assign o_done = st_r.done;
    assign o_err = st_r.err;
    assign o_relock_needed = st_r.relock;
    assign o_status = st_r.status;
    assign o_flash_addr = st_r.pins.addr;
    assign o_dq_out = st_r.pins.dq_out;
    assign o_dq_oe = st_r.pins.dq_oe;
    assign o_ce_n = st_r.pins.ce_n;
    assign o_oe_n = st_r.pins.oe_n;
    assign o_we_n = st_r.pins.we_n;
    assign o_rp_n = st_r.pins.rp_n;
    assign o_wp_n = st_r.pins.wp_n;

    // the confirm write: we_n falls while in S_WR2
    sequence confirm_write_s;
        $fell(o_we_n) && st_r.state == flash_host_pkg::S_WR2;
    endsequence

    lock_confirm_data_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (confirm_write_s and st_r.cmd == flash_host_pkg::CMD_LOCK_SET) |->
        o_dq_out[7:0] == OP_LOCK_SET && o_dq_oe && $stable(o_flash_addr))
        else $error("lock set confirm write malformed");

    clear_two_writes_a: assert property (@(posedge i_clk) disable iff (i_srst)
        st_r.state == flash_host_pkg::S_WR1 && st_r.cmd == flash_host_pkg::CMD_LOCK_CLR &&
        st_r.phase && st_r.cnt == WE_HIGH_LAST && !i_abort |=>
        st_r.state == flash_host_pkg::S_WR2 && o_dq_out[7:0] == OP_LOCK_CLR && !o_we_n)
        else $error("lock clear lacks confirm write");

    set_err_clear_a: assert property (@(posedge i_clk) disable iff (i_srst)
        st_r.state == flash_host_pkg::S_POLL && st_r.phase && st_r.status[`FH_SR_READY] &&
        i_status_pin && !i_abort && st_r.cmd == flash_host_pkg::CMD_LOCK_SET &&
        st_r.status[`FH_SR_SET_ERR] |=>
        st_r.state == flash_host_pkg::S_CLR && o_dq_out[7:0] == OP_CLR_STATUS && o_err)
        else $error("set error not followed by status clear");

    clr_err_clear_a: assert property (@(posedge i_clk) disable iff (i_srst)
        st_r.state == flash_host_pkg::S_POLL && st_r.phase && st_r.status[`FH_SR_READY] &&
        i_status_pin && !i_abort && st_r.cmd == flash_host_pkg::CMD_LOCK_CLR |=>
        (st_r.state == flash_host_pkg::S_CLR) == $past(st_r.status[`FH_SR_CLR_ERR]))
        else $error("clear error handling wrong");

    abort_relock_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_abort && o_busy && st_r.cmd == flash_host_pkg::CMD_LOCK_CLR &&
        st_r.state != flash_host_pkg::S_RST |=> o_relock_needed && !o_rp_n)
        else $error("aborted lock clear not flagged");

    suspend_opcode_a: assert property (@(posedge i_clk) disable iff (i_srst)
        $fell(o_we_n) && st_r.state == flash_host_pkg::S_WR1 &&
        st_r.cmd == flash_host_pkg::CMD_ERS_SUSP |-> o_dq_out[7:0] == OP_ERS_SUSP)
        else $error("erase suspend opcode wrong");

endmodule

//--- sim/flash_dev_model.sv
// behavioural flash device answering suspend, resume and lock-bit commands
`timescale 1ns/1ps
`include "flash_host_params.svh"
module flash_dev_model #(
    parameter int OP_LAT = 12,
    parameter int SUSP_LAT = 3
) (
    // host pins
    input wire logic i_clk,
    input wire logic [`FH_ADDR_W-1:0] i_addr,
    input wire logic [`FH_DATA_W-1:0] i_dq,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_rp_n,
    input wire logic i_wp_n,
    // bench knobs
    input wire logic i_lockout,
    input wire logic i_run_erase,
    input wire logic i_run_prog,
    // observed state
    output logic [`FH_DATA_W-1:0] o_dq,
    output logic o_status_pin,
    output logic [7:0] o_sr,
    output logic [31:0] o_locks
);
    logic [7:0] err = 8'h00;
    logic [15:0] last = 16'h0000;
    logic we_q = 1'b1;
    logic setup = 1'b0;
    logic clr = 1'b0;
    logic e_s = 1'b0;
    logic p_s = 1'b0;
    logic working;
    int eb = 0;
    int pb = 0;
    int lb = 0;
    int pe = 0;
    int pp = 0;
    logic [7:0] op;
    initial o_locks = 32'h0000_0001;
    always_comb working = (eb != 0 && !e_s) || (pb != 0 && !p_s) || lb != 0;
    assign o_sr = {!working, e_s, err[5:3], p_s, err[1:0]};
    // floating pin resolved high by pull-up
    assign o_status_pin = !working;
    // released bus shows the inverse of the last value
    assign o_dq = (!i_ce_n && !i_oe_n) ? {8'h00, o_sr} : ~last;
    // pins sampled mid-cycle, away from the host's launching edge
    always @(negedge i_clk) begin
        we_q <= i_we_n;
        last <= o_dq;
        if (eb != 0 && !e_s) eb <= eb - 1;
        if (pb != 0 && !p_s) pb <= pb - 1;
        if (lb != 0) lb <= lb - 1;
        if (lb == 1 && clr) o_locks <= 32'h0000_0000;
        if (lb == 1) clr <= 1'b0;
        if (pe == 1) e_s <= 1'b1;
        if (pe != 0) pe <= pe - 1;
        if (pp == 1) p_s <= 1'b1;
        if (pp != 0) pp <= pp - 1;
        if (i_run_erase) eb <= OP_LAT * 8;
        if (i_run_prog && (eb == 0 || e_s)) pb <= OP_LAT * 2;
        if (!i_ce_n && !we_q && i_we_n) begin
            op = i_dq[7:0];
            setup <= 1'b0;
            if (setup && op == `FH_OP_LOCK_SET) begin
                if (!i_wp_n) err <= err | 8'h12;
                else begin
                    lb <= OP_LAT;
                    o_locks[i_addr[19:15]] <= 1'b1;
                end
            end else if (setup && op == `FH_OP_LOCK_CLR) begin
                if (i_lockout) err <= err | 8'h28;
                else if (!i_wp_n) err <= err | 8'h22;
                else begin
                    lb <= OP_LAT;
                    clr <= 1'b1;
                end
            end else if (setup) err <= err | 8'h30;
            else if (op == `FH_OP_LOCK_SETUP && !e_s && !p_s) setup <= 1'b1;
            else if (op == `FH_OP_CLR_STATUS) err <= 8'h00;
            else if (op == `FH_OP_PRG_SUSP && pb != 0 && !p_s) pp <= SUSP_LAT;
            else if (op == `FH_OP_ERS_SUSP && eb != 0 && !e_s) pe <= SUSP_LAT;
            else if (op == `FH_OP_PRG_RES && p_s) p_s <= 1'b0;
            else if (op == `FH_OP_ERS_RES && e_s && pb == 0) e_s <= 1'b0;
        end
        if (!i_rp_n) begin
            if (lb != 0 && clr) o_locks <= ~o_locks;
            {eb, pb, lb, pe, pp} <= '0;
            {err, setup, clr, e_s, p_s} <= '0;
        end
    end
endmodule

//--- sim/flash_suspend_lockbit_commands_test.sv
// self-checking bench for the flash suspend and lock-bit command host
`timescale 1ns/1ps
`include "flash_host_params.svh"
module flash_suspend_lockbit_commands_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0;
    flash_host_pkg::cmd_t req_cmd = flash_host_pkg::CMD_LOCK_SET;
    logic [`FH_ADDR_W-1:0] req_addr = 20'h00000;
    logic abort = 1'b0;
    logic unprotect = 1'b0;
    logic lockout = 1'b0;
    logic run_erase = 1'b0;
    logic run_prog = 1'b0;
    logic busy, done, err, relock, ce_n, oe_n, we_n, rp_n, wp_n, sts;
    logic [7:0] status, sr;
    logic [`FH_ADDR_W-1:0] faddr;
    logic [`FH_DATA_W-1:0] dq_out, dq_in;
    logic [31:0] locks;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int lat;
    flash_host DUT (.i_clk(clk), .i_srst(srst), .i_req_valid(req_valid), .i_req_cmd(req_cmd),
        .i_req_addr(req_addr), .i_abort(abort), .i_unprotect(unprotect), .o_busy(busy),
        .o_done(done), .o_err(err), .o_relock_needed(relock), .o_status(status),
        .o_flash_addr(faddr), .o_dq_out(dq_out), .o_dq_oe(), .i_dq_in(dq_in), .o_ce_n(ce_n),
        .o_oe_n(oe_n), .o_we_n(we_n), .o_rp_n(rp_n), .o_wp_n(wp_n), .i_status_pin(sts));
    flash_dev_model dev (.i_clk(clk), .i_addr(faddr), .i_dq(dq_out), .i_ce_n(ce_n),
        .i_oe_n(oe_n), .i_we_n(we_n), .i_rp_n(rp_n), .i_wp_n(wp_n), .i_lockout(lockout),
        .i_run_erase(run_erase), .i_run_prog(run_prog), .o_dq(dq_in), .o_status_pin(sts),
        .o_sr(sr), .o_locks(locks));
    initial forever #50 clk = ~clk;
    task automatic summarize;
        if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one request; ab > 0 pulses abort that many cycles into the wait
    task automatic run(input flash_host_pkg::cmd_t cmd, input logic [19:0] addr, input int ab);
        @(negedge clk);
        req_valid <= 1'b1;
        req_cmd <= cmd;
        req_addr <= addr;
        @(negedge clk);
        req_valid <= 1'b0;
        check(busy, 1);
        lat = 1;
        while (done !== 1'b1 && lat < 400) begin
            abort <= (lat == ab);
            @(negedge clk);
            lat++;
        end
        abort <= 1'b0;
        check(done, 1);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(negedge clk);
        srst <= 1'b0;
        @(negedge clk);
        check(rp_n, 1);
        check(wp_n, 0);
        unprotect <= 1'b1;
        run(flash_host_pkg::CMD_LOCK_SET, 20'h18000, 0);
        check(status, 8'h80);
        check(locks, 32'h0000_0009);
        unprotect <= 1'b0;
        run(flash_host_pkg::CMD_LOCK_SET, 20'h28000, 0);
        check(status, 8'h92);
        check(err, 1);
        check(locks, 32'h0000_0009);
        check(sr, 8'h80);
        run(flash_host_pkg::CMD_LOCK_CLR, 20'h00000, 0);
        check(status, 8'ha2);
        check(sr, 8'h80);
        unprotect <= 1'b1;
        lockout <= 1'b1;
        run(flash_host_pkg::CMD_LOCK_CLR, 20'h00000, 0);
        check(status, 8'ha8);
        check(locks, 32'h0000_0009);
        lockout <= 1'b0;
        run(flash_host_pkg::CMD_LOCK_CLR, 20'h00000, 0);
        check(status, 8'h80);
        check(locks, 32'h0000_0000);
        check(err, 0);
        run(flash_host_pkg::CMD_LOCK_CLR, 20'h00000, 8);
        check(err, 1);
        check(relock, 1);
        run(flash_host_pkg::CMD_LOCK_CLR, 20'h00000, 0);
        check(relock, 0);
        check(locks, 32'h0000_0000);
        run_erase <= 1'b1;
        @(negedge clk);
        run_erase <= 1'b0;
        run(flash_host_pkg::CMD_ERS_SUSP, 20'h40000, 0);
        check(status, 8'hc0);
        run_prog <= 1'b1;
        @(negedge clk);
        run_prog <= 1'b0;
        @(negedge clk);
        check(sr, 8'h40);
        run(flash_host_pkg::CMD_PRG_SUSP, 20'h50000, 0);
        check(status, 8'hc4);
        run(flash_host_pkg::CMD_PRG_RES, 20'h50000, 0);
        check(sr, 8'h40);
        run(flash_host_pkg::CMD_ERS_RES, 20'h40000, 0);
        check(sr, 8'h40);
        lat = 0;
        while (sts !== 1'b1 && lat < 100) begin
            @(negedge clk);
            lat++;
        end
        check(sr, 8'hc0);
        run(flash_host_pkg::CMD_ERS_RES, 20'h40000, 0);
        check(sr, 8'h00);
        check(sts, 0);
        summarize();
    end
endmodule
